// ---- pkg/tcc_pkg.sv ----
// Constants for the timer and capture control block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package tcc_pkg;

    // -----
    // Register word indices (byte address is four times the index)
    // -----
    localparam logic [7:0] IDX_TIMER_CLOCK_CAPTURE_CONFIG = 8'h16;
    localparam logic [7:0] IDX_TIMER_RUN_CAPTURE_STATUS = 8'h17;
    localparam logic [7:0] IDX_CAPTURE34_OUTPUT3_CONTROL = 8'h16;
    localparam logic [7:0] BANK_LOW = 8'h03;
    localparam logic [7:0] BANK_HIGH = 8'h07;
    localparam int BANK_SPAN = 32;
    localparam logic [7:0] IDX_TIMER1 = 8'h00;
    localparam logic [7:0] IDX_TIMER2 = 8'h01;
    localparam logic [7:0] IDX_PERIOD1 = 8'h02;
    localparam logic [7:0] IDX_PERIOD2 = 8'h03;
    localparam logic [7:0] IDX_TIMER3_LO = 8'h04;
    localparam logic [7:0] IDX_TIMER3_HI = 8'h05;
    localparam logic [7:0] IDX_CAPTURE_BASE = 8'h06;
    localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0E;

    // -----
    // Field positions
    // -----
    localparam int POS_FIRST_CLOCK_SELECT = 0;
    localparam int POS_SECOND_CLOCK_SELECT = 1;
    localparam int POS_THIRD_CLOCK_SELECT = 2;
    localparam int POS_COMBINE = 3;
    localparam int POS_CAP1_MODE = 4;
    localparam int POS_CAP2_MODE = 6;
    localparam int POS_FIRST_RUN = 0;
    localparam int POS_SECOND_RUN = 1;
    localparam int POS_THIRD_RUN = 2;
    localparam int POS_PERIOD_OR_CAPTURE = 3;
    localparam int POS_OUTPUT1_ENABLE = 4;
    localparam int POS_OUTPUT2_ENABLE = 5;
    localparam int POS_CAP1_OVERRUN = 6;
    localparam int POS_CAP2_OVERRUN = 7;
    localparam int POS_OUTPUT3_ENABLE = 0;
    localparam int POS_CAP3_MODE = 1;
    localparam int POS_CAP4_MODE = 3;
    localparam int POS_CAP3_OVERRUN = 5;
    localparam int POS_CAP4_OVERRUN = 6;
    localparam int POS_IRQ_FLAG1 = 0;
    localparam int POS_IRQ_FLAG2 = 1;
    localparam int POS_IRQ_ENABLE1 = 2;
    localparam int POS_IRQ_ENABLE2 = 3;
    localparam int POS_PERIPH_ENABLE = 4;
    localparam int POS_GLOBAL_DISABLE = 5;

    // -----
    // Reset values, modes and timing
    // -----
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] MODE_FALL = 2'b00;
    localparam logic [1:0] MODE_RISE = 2'b01;
    localparam logic [1:0] MODE_RISE4 = 2'b10;
    localparam logic [1:0] MODE_RISE16 = 2'b11;
    localparam logic [3:0] PRESCALE4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE16_LAST = 4'hF;
    localparam int INSTR_CYCLE_CLOCKS = 4;

endpackage : tcc_pkg

// ---- verilog/tcc_timer_capture.sv ----
// Two 8-bit period timers (combinable to 16 bits), a 16-bit third timer,
// four input captures and the output pin steering for three outputs.
// Assumes sys_clk is the oscillator clock and pins arrive asynchronously.
`timescale 1ns/1ps

// How it works
// - Two 8-bit up timers, each with own period register and own flag.
// - Third 16-bit timer; extra pair is its period or capture one.
// - Capture mode: 00 falling, 01 rising, 10 fourth rise, 11 sixteenth.
// - Capture mode fields sit in config bits 7-6, 5-4 and control 4-3, 2-1.
// - Combine bit and second run bit both set join the two 8-bit timers into one 16-bit timer.
// - Third timer clocks on falling edges of its own pin when selected.
// - Each 8-bit timer counts instruction cycles or shared pin falls.
// - Capture before both bytes read sets overrun, keeps old value.
// - Overrun flags are read-only, reset to zero, at the listed bits.
// - Output enable forces its pin driven by the pulse output.
// - Third timer counts only while its run bit is set.
// - First run bit gates the combined timer, else only the first.
// - An 8-bit timer counts from zero to its period, then back to zero.
// - A timer's flag is set when it returns to zero after match.
// - Timer interrupt needs its enable, peripheral enable, no global off.
// - A stopped timer neither counts nor sets its flag.
// - All captures take the third timer's current 16-bit count.
// - Combined timer returns to zero after pair match, sets first flag.
// - External timer clocks are synchronised before they count.
module tcc_timer_capture
    import tcc_pkg::*;
#(
    parameter int ADR_W = 10,
    parameter int INSTR_DIV = INSTR_CYCLE_CLOCKS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External clock and capture pins
    input wire logic shared_timer_clock_pin,
    input wire logic third_timer_clock_pin,
    input wire logic [3:0] capture_pin,
    // Output pin steering
    input wire logic [2:0] pulse_level,
    input wire logic [2:0] port_data,
    input wire logic [2:0] port_direction_input,
    output logic [2:0] out_pin_o,
    output logic [2:0] out_pin_oe,
    // Interrupt requests to the processor
    output logic first_timer_irq,
    output logic second_timer_irq
);

    // -----
    // Bus decode
    // -----
    logic [7:0] word_idx;
    logic bus_req;
    logic wr_en;
    logic rd_en;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic idx_config;
    logic idx_status;
    logic idx_cap34;

    assign word_idx = wb_adr_i[ADR_W-1:2];
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
    assign rd_en = bus_req & ~wb_we_i;
    assign wdata = wb_dat_i[7:0];
    // Banks are folded into the word index so both shared offsets coexist.
    assign idx_config = word_idx ==
        8'(BANK_LOW * BANK_SPAN + IDX_TIMER_CLOCK_CAPTURE_CONFIG);
    assign idx_status = word_idx ==
        8'(BANK_LOW * BANK_SPAN + IDX_TIMER_RUN_CAPTURE_STATUS);
    assign idx_cap34 = word_idx ==
        8'(BANK_HIGH * BANK_SPAN + IDX_CAPTURE34_OUTPUT3_CONTROL);

    // -----
    // Control registers
    // -----
    logic [7:0] config_reg;
    logic [5:0] run_ctrl_reg;
    logic [4:0] cap34_ctrl_reg;
    logic [7:0] period1_reg;
    logic [7:0] period2_reg;
    logic [3:0] irq_en_reg;
    logic [1:0] irq_flag_reg;
    logic [3:0] overrun_reg;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            config_reg <= RESET_BYTE;
            run_ctrl_reg <= 6'h00;
            cap34_ctrl_reg <= 5'h00;
            period1_reg <= RESET_BYTE;
            period2_reg <= RESET_BYTE;
            irq_en_reg <= 4'h0;
        end else if (wr_en) begin
            if (idx_config) begin
                config_reg <= wdata;
            end
            if (idx_status) begin
                run_ctrl_reg <= wdata[5:0];
            end
            if (idx_cap34) begin
                cap34_ctrl_reg <= wdata[4:0];
            end
            if (word_idx == IDX_PERIOD1) begin
                period1_reg <= wdata;
            end
            if (word_idx == IDX_PERIOD2) begin
                period2_reg <= wdata;
            end
            if (word_idx == IDX_IRQ_CONTROL) begin
                irq_en_reg <= wdata[POS_GLOBAL_DISABLE:POS_IRQ_ENABLE1];
            end
        end
    end

    logic combine;
    logic first_run;
    logic second_run;
    logic third_run;
    logic capture1_mode;
    logic [1:0] cap_mode [4];

    assign combine = config_reg[POS_COMBINE];
    assign first_run = run_ctrl_reg[POS_FIRST_RUN];
    assign second_run = run_ctrl_reg[POS_SECOND_RUN];
    assign third_run = run_ctrl_reg[POS_THIRD_RUN];
    assign capture1_mode = run_ctrl_reg[POS_PERIOD_OR_CAPTURE];
    assign cap_mode[0] = config_reg[POS_CAP1_MODE +: 2];
    assign cap_mode[1] = config_reg[POS_CAP2_MODE +: 2];
    assign cap_mode[2] = cap34_ctrl_reg[POS_CAP3_MODE +: 2];
    assign cap_mode[3] = cap34_ctrl_reg[POS_CAP4_MODE +: 2];

    // -----
    // Instruction cycle enable and external clock edges
    // -----
    logic [7:0] div_reg;
    logic instr_en;

    assign instr_en = div_reg == 8'(INSTR_DIV - 1);

    always_ff @(posedge sys_clk) begin
        if (reset || instr_en) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // Sampling every oscillator clock is finer than twice per cycle.
    logic [2:0] clk12_sync_reg;
    logic [2:0] clk3_sync_reg;
    logic clk12_fall;
    logic clk3_fall;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clk12_sync_reg <= 3'b000;
            clk3_sync_reg <= 3'b000;
        end else begin
            clk12_sync_reg <= {clk12_sync_reg[1:0], shared_timer_clock_pin};
            clk3_sync_reg <= {clk3_sync_reg[1:0], third_timer_clock_pin};
        end
    end

    assign clk12_fall = clk12_sync_reg[2] & ~clk12_sync_reg[1];
    assign clk3_fall = clk3_sync_reg[2] & ~clk3_sync_reg[1];

    // -----
    // First and second timers
    // -----
    logic [7:0] timer1_reg;
    logic [7:0] timer2_reg;
    logic tick1;
    logic tick2;
    logic joined;
    logic wrap1;
    logic wrap2;
    logic wrap16;

    assign tick1 = config_reg[POS_FIRST_CLOCK_SELECT] ? clk12_fall
                                                      : instr_en;
    assign tick2 = config_reg[POS_SECOND_CLOCK_SELECT] ? clk12_fall
                                                       : instr_en;
    // Without the second run bit only the low byte advances.
    assign joined = combine & second_run;
    assign wrap16 = {timer2_reg, timer1_reg} == {period2_reg, period1_reg};
    assign wrap1 = timer1_reg == period1_reg;
    assign wrap2 = timer2_reg == period2_reg;

    logic set_flag1;
    logic set_flag2;

    assign set_flag1 = first_run & tick1 & (joined ? wrap16 : wrap1);
    assign set_flag2 = ~combine & second_run & tick2 & wrap2;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timer1_reg <= RESET_BYTE;
            timer2_reg <= RESET_BYTE;
        end else begin
            if (first_run && tick1) begin
                if (joined) begin
                    if (wrap16) begin
                        timer1_reg <= RESET_BYTE;
                        timer2_reg <= RESET_BYTE;
                    end else begin
                        {timer2_reg, timer1_reg} <=
                            {timer2_reg, timer1_reg} + 16'h0001;
                    end
                end else begin
                    timer1_reg <= wrap1 ? RESET_BYTE
                                        : timer1_reg + 8'h01;
                end
            end
            if (!combine && second_run && tick2) begin
                timer2_reg <= wrap2 ? RESET_BYTE
                                    : timer2_reg + 8'h01;
            end
            // A software write overrides a count in the same cycle.
            if (wr_en && word_idx == IDX_TIMER1) begin
                timer1_reg <= wdata;
            end
            if (wr_en && word_idx == IDX_TIMER2) begin
                timer2_reg <= wdata;
            end
        end
    end

    // -----
    // Timer flags and interrupt requests
    // -----
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_flag_reg <= 2'b00;
        end else if (wr_en && word_idx == IDX_IRQ_CONTROL) begin
            // Writing zero clears a flag; a new event in that cycle wins.
            irq_flag_reg <= (irq_flag_reg & wdata[1:0])
                          | {set_flag2, set_flag1};
        end else begin
            irq_flag_reg <= irq_flag_reg | {set_flag2, set_flag1};
        end
    end

    logic irq_gate;

    assign irq_gate = irq_en_reg[POS_PERIPH_ENABLE - POS_IRQ_ENABLE1]
                    & ~irq_en_reg[POS_GLOBAL_DISABLE - POS_IRQ_ENABLE1];
    assign first_timer_irq = irq_flag_reg[POS_IRQ_FLAG1] & irq_gate
                           & irq_en_reg[0];
    assign second_timer_irq = irq_flag_reg[POS_IRQ_FLAG2] & irq_gate
                            & irq_en_reg[1];

    // -----
    // Third timer
    // -----
    logic [15:0] timer3_reg;
    logic [15:0] cap_value [4];
    logic tick3;

    assign tick3 = config_reg[POS_THIRD_CLOCK_SELECT] ? clk3_fall
                                                      : instr_en;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timer3_reg <= 16'h0000;
        end else begin
            if (third_run && tick3) begin
                if (!capture1_mode && timer3_reg == cap_value[0]) begin
                    timer3_reg <= 16'h0000;
                end else begin
                    timer3_reg <= timer3_reg + 16'h0001;
                end
            end
            if (wr_en && word_idx == IDX_TIMER3_LO) begin
                timer3_reg[7:0] <= wdata;
            end
            if (wr_en && word_idx == IDX_TIMER3_HI) begin
                timer3_reg[15:8] <= wdata;
            end
        end
    end

    // -----
    // Capture channels
    // -----
    logic [7:0] cap_rd [4];

    for (genvar ch = 0; ch < 4; ch++) begin : g_cap
        logic [2:0] sync_reg;
        logic [1:0] mode_seen_reg;
        logic [3:0] prescale_reg;
        logic [15:0] value_reg;
        logic pending_reg;
        logic lo_read_reg;
        logic hi_read_reg;
        logic rise;
        logic fall;
        logic event_hit;
        logic active;
        logic lo_hit;
        logic hi_hit;
        logic both_read;

        assign rise = sync_reg[1] & ~sync_reg[2];
        assign fall = sync_reg[2] & ~sync_reg[1];
        assign active = (ch != 0) | capture1_mode;
        assign lo_hit = word_idx == 8'(IDX_CAPTURE_BASE + 2 * ch);
        assign hi_hit = word_idx == 8'(IDX_CAPTURE_BASE + 2 * ch + 1);
        assign both_read = (lo_read_reg | (rd_en & lo_hit))
                         & (hi_read_reg | (rd_en & hi_hit));

        always_comb begin
            unique case (cap_mode[ch])
                MODE_FALL: event_hit = fall;
                MODE_RISE: event_hit = rise;
                MODE_RISE4: event_hit = rise & (prescale_reg == PRESCALE4_LAST);
                MODE_RISE16: event_hit = rise
                    & (prescale_reg == PRESCALE16_LAST);
            endcase
        end

        always_ff @(posedge sys_clk) begin
            if (reset) begin
                sync_reg <= 3'b000;
                mode_seen_reg <= MODE_FALL;
                prescale_reg <= 4'h0;
            end else begin
                sync_reg <= {sync_reg[1:0], capture_pin[ch]};
                mode_seen_reg <= cap_mode[ch];
                if (mode_seen_reg != cap_mode[ch]) begin
                    prescale_reg <= 4'h0;
                end else if (rise) begin
                    prescale_reg <= (cap_mode[ch] == MODE_RISE4
                        && prescale_reg == PRESCALE4_LAST) ? 4'h0
                        : prescale_reg + 4'h1;
                end
            end
        end

        always_ff @(posedge sys_clk) begin
            if (reset) begin
                value_reg <= 16'h0000;
                pending_reg <= 1'b0;
                lo_read_reg <= 1'b0;
                hi_read_reg <= 1'b0;
                overrun_reg[ch] <= 1'b0;
            end else begin
                if (rd_en && lo_hit) begin
                    lo_read_reg <= 1'b1;
                end
                if (rd_en && hi_hit) begin
                    hi_read_reg <= 1'b1;
                end
                if (pending_reg && both_read) begin
                    pending_reg <= 1'b0;
                    overrun_reg[ch] <= 1'b0;
                end
                if (active && event_hit) begin
                    if (pending_reg && !both_read) begin
                        overrun_reg[ch] <= 1'b1;
                    end else begin
                        value_reg <= timer3_reg;
                        pending_reg <= 1'b1;
                        lo_read_reg <= 1'b0;
                        hi_read_reg <= 1'b0;
                    end
                end
                // In period mode the first pair is a writable period.
                if (ch == 0 && !capture1_mode && wr_en && lo_hit) begin
                    value_reg[7:0] <= wdata;
                end
                if (ch == 0 && !capture1_mode && wr_en && hi_hit) begin
                    value_reg[15:8] <= wdata;
                end
            end
        end

        assign cap_value[ch] = value_reg;
        assign cap_rd[ch] = (lo_hit ? value_reg[7:0] : 8'h00)
                          | (hi_hit ? value_reg[15:8] : 8'h00);
    end

    // -----
    // Read data and acknowledge
    // -----
    always_comb begin
        rdata = cap_rd[0] | cap_rd[1] | cap_rd[2] | cap_rd[3];
        if (idx_config) begin
            rdata = config_reg;
        end else if (idx_status) begin
            rdata = {overrun_reg[1], overrun_reg[0], run_ctrl_reg};
        end else if (idx_cap34) begin
            rdata = {1'b0, overrun_reg[3], overrun_reg[2],
                     cap34_ctrl_reg};
        end else if (word_idx == IDX_TIMER1) begin
            rdata = timer1_reg;
        end else if (word_idx == IDX_TIMER2) begin
            rdata = timer2_reg;
        end else if (word_idx == IDX_PERIOD1) begin
            rdata = period1_reg;
        end else if (word_idx == IDX_PERIOD2) begin
            rdata = period2_reg;
        end else if (word_idx == IDX_TIMER3_LO) begin
            rdata = timer3_reg[7:0];
        end else if (word_idx == IDX_TIMER3_HI) begin
            rdata = timer3_reg[15:8];
        end else if (word_idx == IDX_IRQ_CONTROL) begin
            rdata = {2'b00, irq_en_reg, irq_flag_reg};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (rd_en) begin
                wb_dat_o <= {24'h00_0000, rdata};
            end
        end
    end

    // -----
    // Output pin steering
    // -----
    logic [2:0] out_enable;

    assign out_enable = {cap34_ctrl_reg[POS_OUTPUT3_ENABLE],
                         run_ctrl_reg[POS_OUTPUT2_ENABLE],
                         run_ctrl_reg[POS_OUTPUT1_ENABLE]};

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_pin_o <= 3'b000;
            out_pin_oe <= 3'b000;
        end else begin
            out_pin_o <= (out_enable & pulse_level)
                       | (~out_enable & port_data);
            out_pin_oe <= out_enable | ~port_direction_input;
        end
    end

endmodule : tcc_timer_capture

// ---- tb/tcc_timer_capture_sva.sv ----
// Checker for the bus answer and the pin steering of the timer block.
// Assumes it is bound to tcc_timer_capture and sees only its ports.
`timescale 1ns/1ps
module tcc_timer_capture_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and requests
    input wire logic [2:0] pulse_level,
    input wire logic [2:0] port_data,
    input wire logic [2:0] port_direction_input,
    input wire logic [2:0] out_pin_o,
    input wire logic [2:0] out_pin_oe,
    input wire logic first_timer_irq,
    input wire logic second_timer_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_dat_upper;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
    endproperty
    a_dat_upper: assert property (p_dat_upper) else $error("upper data");
    // Read data must survive writes, so software may read it late.
    property p_dat_hold;
        !(wb_cyc_i && wb_stb_i && !wb_we_i) |=> $stable(wb_dat_o);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("data moved");
    property p_oe_dir;
        1'b1 |=> (~$past(port_direction_input) & ~out_pin_oe) == 3'b000;
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("pin undriven");
    property p_pin_hold;
        $stable(port_data) && $stable(pulse_level) && !(wb_cyc_i && wb_we_i)
            && $stable(port_direction_input)
            |=> $stable(out_pin_o) && $stable(out_pin_oe);
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin moved");
    property p_irq_reset;
        $past(reset) |-> !first_timer_irq && !second_timer_irq;
    endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("irq at reset");
endmodule : tcc_timer_capture_sva
bind tcc_timer_capture tcc_timer_capture_sva u_sva (.sys_clk(sys_clk),
    .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pulse_level(pulse_level), .port_data(port_data),
    .port_direction_input(port_direction_input), .out_pin_o(out_pin_o),
    .out_pin_oe(out_pin_oe), .first_timer_irq(first_timer_irq),
    .second_timer_irq(second_timer_irq));

// ---- tb/tcc_pins_model.sv ----
// Far-side pins: the two external timer clocks and four capture inputs.
// Assumes the bench calls its tasks; pins move only after rising edges.
`timescale 1ns/1ps
module tcc_pins_model (
    // Clock
    input wire logic sys_clk,
    // Pins towards the block, clock bit 0 shared, bit 1 third timer
    output logic [1:0] ext_clk_pin,
    output logic [3:0] capture_pin
);
    initial begin
        ext_clk_pin = 2'b11;
        capture_pin = 4'h0;
    end
    // Levels stand four clocks or more so the synchroniser never misses one.
    task automatic clk_falls(input int sel, input int n);
        repeat (n) begin
            @(posedge sys_clk) ext_clk_pin[sel] <= 1'b0;
            repeat (4) @(posedge sys_clk);
            ext_clk_pin[sel] <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
    endtask : clk_falls
    task automatic cap_pulse(input int ch);
        @(posedge sys_clk) capture_pin[ch] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        capture_pin[ch] <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask : cap_pulse
endmodule : tcc_pins_model

// ---- tb/tcc_timer_capture_tb.sv ----
// Self-checking bench for the timer and capture block.
// Assumes the pin model answers the task calls made here.
`timescale 1ns/1ps
module tcc_timer_capture_tb;
    logic sys_clk = 0, reset = 1, cyc = 0, stb = 0, we = 0;
    logic [9:0] adr = '0;
    logic [31:0] wdat = '0, rdat;
    logic ack, irq1, irq2;
    logic [2:0] lvl = '0, pdat = '0, pdir = '1, pin_o, pin_oe;
    logic [1:0] ext_clk;
    logic [3:0] cap, sel = '0;
    logic [17:0] exp_q[$];
    logic [7:0] irq_wr[4] = '{8'h35, 8'h05, 8'h11, 8'h15};
    int err_total = 0, n_checks = 0, cyc_cnt = 0, n, r;
    always #20 sys_clk = ~sys_clk;
    tcc_timer_capture u_tcc_timer_capture (.sys_clk(sys_clk), .reset(reset),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .shared_timer_clock_pin(ext_clk[0]), .capture_pin(cap),
        .third_timer_clock_pin(ext_clk[1]), .pulse_level(lvl),
        .port_data(pdat), .port_direction_input(pdir), .out_pin_o(pin_o),
        .out_pin_oe(pin_oe), .first_timer_irq(irq1),
        .second_timer_irq(irq2));
    tcc_pins_model u_tcc_pins_model (.sys_clk(sys_clk),
        .ext_clk_pin(ext_clk), .capture_pin(cap));
    task automatic wb(input logic [9:0] a, input logic w, input logic [7:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= a;
        wdat <= {24'h00_0000, d};
        do @(posedge sys_clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        exp_q.push_back({a, e});
        wb(a, 1'b0, 8'h00);
    endtask : rd
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_irq(input int lim);
        n = 0;
        while (irq1 !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_irq
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    always @(posedge sys_clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            chk($sformatf("reg %h", exp_q[0][17:8]), exp_q[0][7:0], rdat[7:0]);
            chk("rd_upper", 8'h00, {7'h0, |rdat[31:8]});
            void'(exp_q.pop_front());
        end
    end
    always @(posedge sys_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        r = $urandom(33);
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        rd(10'h1D8, 8'h00);
        rd(10'h1DC, 8'h00);
        rd(10'h3D8, 8'h00);
        rd(10'h3FC, 8'h00);
        r = $urandom;
        wb(10'h1D8, 1'b1, r[7:0]);
        rd(10'h1D8, r[7:0]);
        wb(10'h1DC, 1'b1, 8'hFF);
        rd(10'h1DC, 8'h3F);
        wb(10'h3D8, 1'b1, 8'hFF);
        rd(10'h3D8, 8'h1F);
        $display("test registers done");
        lvl <= r[10:8];
        pdat <= r[13:11];
        wb(10'h1DC, 1'b1, 8'h10);
        wb(10'h3D8, 1'b1, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk("pin_oe", 8'h05, {5'h0, pin_oe});
        chk("pin_lvl", {5'h0, r[10], 1'b0, r[8]}, {5'h0, pin_o & 3'b101});
        pdir <= 3'b000;
        repeat (2) @(posedge sys_clk);
        chk("pin_dir", 8'h07, {5'h0, pin_oe});
        $display("test pins done");
        wb(10'h08, 1'b1, 8'h03);
        wb(10'h00, 1'b1, 8'h00);
        wb(10'h38, 1'b1, 8'h14);
        wb(10'h1DC, 1'b1, 8'h01);
        wait_irq(40);
        chk("wrap_time", 8'h01, {7'h0, n >= 10 && n <= 18});
        foreach (irq_wr[i]) begin
            wb(10'h38, 1'b1, irq_wr[i]);
            chk("irq_gate", {7'h0, i == 3}, {7'h0, irq1});
        end
        wb(10'h1DC, 1'b1, 8'h00);
        wb(10'h38, 1'b1, 8'h1C);
        repeat (40) @(posedge sys_clk);
        chk("irq_stopped", 8'h00, {7'h0, irq1});
        wb(10'h1D8, 1'b1, 8'h08);
        wb(10'h0C, 1'b1, 8'h01);
        wb(10'h00, 1'b1, 8'h00);
        wb(10'h04, 1'b1, 8'h00);
        wb(10'h1DC, 1'b1, 8'h03);
        wait_irq(1200);
        chk("wrap16", 8'h01, {7'h0, n >= 1000 && n <= 1040});
        chk("irq2", 8'h00, {7'h0, irq2});
        $display("test timers done");
        wb(10'h1D8, 1'b1, 8'h04);
        wb(10'h1DC, 1'b1, 8'h0C);
        wb(10'h10, 1'b1, 8'h00);
        wb(10'h14, 1'b1, 8'h00);
        u_tcc_pins_model.clk_falls(1, 5);
        rd(10'h10, 8'h05);
        wb(10'h1DC, 1'b1, 8'h08);
        u_tcc_pins_model.clk_falls(1, 3);
        rd(10'h10, 8'h05);
        $display("test external clock done");
        for (int m = 0; m < 4; m++) begin
            wb(10'h1D8, 1'b1, 8'(m << 4));
            wb(10'h10, 1'b1, 8'h20);
            repeat (m < 2 ? 0 : m == 2 ? 3 : 15) u_tcc_pins_model.cap_pulse(0);
            wb(10'h10, 1'b1, 8'h40 + 8'(m));
            u_tcc_pins_model.cap_pulse(0);
            rd(10'h18, 8'h40 + 8'(m));
            rd(10'h1C, 8'h00);
        end
        wb(10'h10, 1'b1, 8'h55);
        wb(10'h1D8, 1'b1, 8'h10);
        u_tcc_pins_model.cap_pulse(0);
        wb(10'h10, 1'b1, 8'h66);
        u_tcc_pins_model.cap_pulse(0);
        rd(10'h1DC, 8'h48);
        rd(10'h18, 8'h55);
        rd(10'h1C, 8'h00);
        wb(10'h10, 1'b1, 8'h77);
        u_tcc_pins_model.cap_pulse(0);
        rd(10'h18, 8'h77);
        $display("test captures done");
        finish_test();
    end
endmodule : tcc_timer_capture_tb
